/* mpt_pkg.sv */
/*
 * mpt_pkg: constants and carrier types for the module power toggle
 * and reboot sequencer.
 * Assumes a single 100 MHz clock; times are converted to cycle counts.
 */
package mpt_pkg;

   localparam int unsigned CLK_PERIOD_NS     = 10;
   localparam int unsigned TOGGLE_MIN_MS     = 1000;
   localparam int unsigned REBOOT_MIN_MS     = 200;
   localparam int unsigned TOGGLE_MIN_CYC    =
      (TOGGLE_MIN_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned REBOOT_MIN_CYC    =
      (REBOOT_MIN_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned PULSE_CNT_W       = 27;
   localparam int unsigned DETACH_WAIT_CYC_D = 16;
   localparam logic        POWER_STATE_RST   = 1'b0;

   typedef enum logic [2:0]
   {
      MPT_OFF       = 3'b000,
      MPT_ON        = 3'b001,
      MPT_DETACH    = 3'b010,
      MPT_DOWN      = 3'b011,
      MPT_REBOOT    = 3'b100
   } mpt_state_t;

   // qualified pulse events from the pad filters
   typedef struct packed
   {
      logic toggle;
      logic reboot;
   } mpt_evt_t;

endpackage : mpt_pkg

/* mpt_pulse_qual.sv */
/*
 * mpt_pulse_qual: measures a low pulse on an active-low pad and emits a
 * one-cycle event at release when the pulse lasted the minimum time.
 * Assumes the pad input is synchronous to clk_in.
 */
`timescale 1ns/1ns
module mpt_pulse_qual
   import mpt_pkg::*;
#(
   parameter int unsigned MIN_CYC = 100
)
(
   input  wire logic clk_in,
   input  wire logic sys_rst_in,
   input  wire logic pad_n_in,
   output logic      qualified_out
);

   logic [PULSE_CNT_W-1:0] low_cnt_q;
   logic                   long_q;
   logic                   pad_n_q;

   always_ff @(posedge clk_in)
   begin
      if (sys_rst_in)
      begin
         low_cnt_q <= '0;
         long_q    <= 1'b0;
      end
      else if (!pad_n_in)
      begin
         if (low_cnt_q < PULSE_CNT_W'(MIN_CYC))
            low_cnt_q <= low_cnt_q + 1'b1;
         long_q <= (low_cnt_q >= PULSE_CNT_W'(MIN_CYC - 1));
      end
      else
      begin
         low_cnt_q <= '0;
         long_q    <= 1'b0;
      end
   end

   always_ff @(posedge clk_in)
   begin
      if (sys_rst_in)
         pad_n_q <= 1'b1;
      else
         pad_n_q <= pad_n_in;
   end

   // event fires on the rising edge of the pad, short pulses ignored
   assign qualified_out = pad_n_in && !pad_n_q && long_q;

endmodule : mpt_pulse_qual

/* mpt_power_seq.sv */
/*
 * mpt_power_seq: power on/off toggle and unconditional reboot sequencer
 * of a cellular radio module.
 * Assumes the toggle pad is driven open-collector and the reboot pad both ways
 * by the host, both synchronous to clk_in; the detach handshake is answered by the protocol stack.
 */
`timescale 1ns/1ns
module mpt_power_seq
   import mpt_pkg::*;
(
   input  wire logic clk_in,
   input  wire logic sys_rst_in,
   input  wire logic power_toggle_n_in,
   input  wire logic reboot_n_in,
   input  wire logic charger_present_in,
   input  wire logic battery_supply_in,
   input  wire logic sw_power_down_in,
   input  wire logic detach_done_in,
   output logic      toggle_pullup_en_out,
   output logic      detach_req_out,
   output logic      core_enable_out,
   output logic      core_reset_n_out,
   output logic      power_state_out
);

   ////////////////////////////////////////////////////////////////////////
   // pad qualification

   mpt_evt_t   evt;
   mpt_state_t state_q;
   mpt_state_t state_d;
   logic       chg_q;
   logic       charger_rise;

   mpt_pulse_qual #(
      .MIN_CYC       (TOGGLE_MIN_CYC)
   ) u_toggle_qual (
      .clk_in        (clk_in),
      .sys_rst_in    (sys_rst_in),
      .pad_n_in      (power_toggle_n_in),
      .qualified_out (evt.toggle)
   );

   mpt_pulse_qual #(
      .MIN_CYC       (REBOOT_MIN_CYC)
   ) u_reboot_qual (
      .clk_in        (clk_in),
      .sys_rst_in    (sys_rst_in),
      .pad_n_in      (reboot_n_in),
      .qualified_out (evt.reboot)
   );

   // internal weak pull-up is always enabled
   assign toggle_pullup_en_out = 1'b1;

   always_ff @(posedge clk_in)
   begin
      if (sys_rst_in)
         chg_q <= 1'b0;
      else
         chg_q <= charger_present_in;
   end

   assign charger_rise = charger_present_in && !chg_q;

   ////////////////////////////////////////////////////////////////////////
   // power state machine

   always_comb
   begin
      state_d = state_q;
      case (state_q)
         MPT_OFF:
         begin
            if (evt.toggle)
               state_d = MPT_ON;
            else if (charger_rise && battery_supply_in)
               state_d = MPT_ON;
         end
         MPT_ON:
         begin
            if (evt.reboot)
               state_d = MPT_REBOOT;
            else if (evt.toggle || sw_power_down_in)
               state_d = MPT_DETACH;
         end
         MPT_DETACH:
         begin
            if (evt.reboot)
               state_d = MPT_REBOOT;
            else if (detach_done_in)
               state_d = MPT_DOWN;
         end
         MPT_DOWN:
            state_d = MPT_OFF;
         MPT_REBOOT:
            state_d = MPT_ON;
         default:
            state_d = MPT_OFF;
      endcase
   end

   always_ff @(posedge clk_in)
   begin
      if (sys_rst_in)
         state_q <= MPT_OFF;
      else
         state_q <= state_d;
   end

   ////////////////////////////////////////////////////////////////////////
   // outputs

   always_ff @(posedge clk_in)
   begin
      if (sys_rst_in)
      begin
         power_state_out  <= POWER_STATE_RST;
         core_enable_out  <= 1'b0;
         core_reset_n_out <= 1'b0;
         detach_req_out   <= 1'b0;
      end
      else
      begin
         power_state_out  <= (state_d != MPT_OFF);
         core_enable_out  <= (state_d != MPT_OFF) &&
                             (state_d != MPT_DOWN);
         core_reset_n_out <= (state_d == MPT_ON) ||
                             (state_d == MPT_DETACH);
         detach_req_out   <= (state_d == MPT_DETACH);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // checks

   a_off_when_down: assert property (@(posedge clk_in)
      disable iff (sys_rst_in)
      (state_q == MPT_DOWN) |=> !power_state_out && state_q == MPT_OFF)
      else $error("power state not low after shutdown");

   a_detach_before_down: assert property (@(posedge clk_in)
      disable iff (sys_rst_in)
      (state_q == MPT_DOWN) |-> $past(state_q) == MPT_DETACH)
      else $error("power down without detach");

   a_release_first: assert property (@(posedge clk_in)
      disable iff (sys_rst_in)
      (state_q == MPT_ON && !power_toggle_n_in && !sw_power_down_in)
      |=> !detach_req_out)
      else $error("shutdown begun while pad held low");

   a_toggle_turns_on: assert property (@(posedge clk_in)
      disable iff (sys_rst_in)
      (state_q == MPT_OFF && evt.toggle)
      |=> power_state_out && core_enable_out)
      else $error("toggle did not power on");

   a_sw_request: assert property (@(posedge clk_in)
      disable iff (sys_rst_in)
      (state_q == MPT_ON && sw_power_down_in && !evt.reboot)
      |=> detach_req_out)
      else $error("software power down ignored");

   a_short_ignored: assert property (@(posedge clk_in)
      disable iff (sys_rst_in)
      (reboot_n_in && !$past(reboot_n_in) && $past(reboot_n_in, 2))
      |-> !evt.reboot)
      else $error("one-cycle reboot pulse accepted");

   a_charger_on: assert property (@(posedge clk_in)
      disable iff (sys_rst_in)
      (state_q == MPT_OFF && charger_rise && battery_supply_in)
      |=> state_q == MPT_ON)
      else $error("charger did not power on");

   a_pullup_on: assert property (@(posedge clk_in)
      disable iff (sys_rst_in)
      toggle_pullup_en_out)
      else $error("toggle pull-up disabled");

endmodule : mpt_power_seq

/* mpt_host_model.sv */
/* mpt_host_model: host pad drivers and network detach answer.
   Assumes the same clock as the sequencer. */
`timescale 1ns/1ns
module mpt_host_model
(
   input  wire logic       clk_in,
   input  wire logic       pullup_en_in,
   input  wire logic       tog_low_in,
   input  wire logic       rst_low_in,
   input  wire logic       detach_req_in,
   input  wire logic [7:0] delay_in,
   output logic            tog_pad_out,
   output logic            rst_pad_out,
   output logic            detach_done_out
);
   logic [7:0] wait_q;
   // toggle pad open collector: pulls low only, the pull-up gives the high level; reset pad driven both ways
   assign tog_pad_out = tog_low_in ? 1'b0 : pullup_en_in;
   assign rst_pad_out = ~rst_low_in;
   always_ff @(posedge clk_in)
   begin
      wait_q <= detach_req_in ? wait_q + 8'h01 : 8'h00;
      detach_done_out <= detach_req_in && (wait_q >= delay_in);
   end
endmodule : mpt_host_model

/* module_power_toggle_and_reboot_tb.sv */
/* module_power_toggle_and_reboot_tb: self-checking bench of the sequencer.
   Assumes the host model answers detach; qualifying pulses outlast the
   run, so only short pad pulses are driven and must be ignored. */
`timescale 1ns/1ns
module module_power_toggle_and_reboot_tb;
   import mpt_pkg::*;
   logic       clk_in = 1'b0;
   logic       sys_rst_in = 1'b1;
   logic       tog_low = 1'b0;
   logic       rst_low = 1'b0;
   logic       chg = 1'b0;
   logic       batt = 1'b0;
   logic       sw_dn = 1'b0;
   logic [7:0] dly = 8'h00;
   logic       tog_pad, rst_pad, done, pu_en, det, en, rstn, ps;
   logic [2:0] obs_q;
   logic [2:0] exp_q[$];
   int         err_total = 0;
   int         checked = 0;

   initial forever #5 clk_in = ~clk_in;

   mpt_power_seq u_dut (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
      .power_toggle_n_in(tog_pad), .reboot_n_in(rst_pad),
      .charger_present_in(chg), .battery_supply_in(batt),
      .sw_power_down_in(sw_dn), .detach_done_in(done),
      .toggle_pullup_en_out(pu_en), .detach_req_out(det),
      .core_enable_out(en), .core_reset_n_out(rstn),
      .power_state_out(ps));
   mpt_host_model u_host (.clk_in(clk_in), .pullup_en_in(pu_en),
      .tog_low_in(tog_low), .rst_low_in(rst_low), .detach_req_in(det),
      .delay_in(dly), .tog_pad_out(tog_pad), .rst_pad_out(rst_pad),
      .detach_done_out(done));

   ////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [4:0] seen, input logic [4:0] want);
      checked++;
      if (seen !== want)
      begin
         err_total++;
         $display("MISMATCH t=%0t seen %b want %b", $time, seen, want);
      end
   endtask : chk

   // pad 0 toggle, 1 reboot, other software power down
   task automatic press(input int unsigned pad, input int unsigned n);
      case (pad)
         0: tog_low <= 1'b1;
         1: rst_low <= 1'b1;
         default: sw_dn <= 1'b1;
      endcase
      repeat (n) @(posedge clk_in);
      case (pad)
         0: tog_low <= 1'b0;
         1: rst_low <= 1'b0;
         default: sw_dn <= 1'b0;
      endcase
   endtask : press

   task automatic end_of_test;
      $display("checks %0d errors %0d", checked, err_total);
      if (err_total == 0 && checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : end_of_test

   ////////////////////////////////////////////////////////////////////
   // an output change with no note queued compares against the old value
   always @(negedge clk_in)
   begin
      if (sys_rst_in)
         obs_q <= {det, en, ps};
      else if ({det, en, ps} !== obs_q)
      begin
         obs_q <= {det, en, ps};
         chk({2'b00, det, en, ps},
             {2'b00, exp_q.size() > 0 ? exp_q.pop_front() : obs_q});
      end
   end

   initial
   begin
      repeat (5000) @(posedge clk_in);
      err_total++;
      end_of_test();
   end

   initial
   begin
      void'($urandom(32'hc1d4));
      repeat (10) @(posedge clk_in);
      sys_rst_in <= 1'b0;
      repeat (2) @(negedge clk_in);
      chk({det, en, ps, rstn, pu_en}, 5'h01);
      @(posedge clk_in);
      press(0, $urandom_range(1, 200));
      chg <= 1'b1;
      repeat (5) @(posedge clk_in);
      for (int i = 0; i < 2; i++)
      begin
         chg <= 1'b0;
         batt <= 1'b1;
         dly <= (i == 1) ? 8'hc8 : 8'($urandom_range(0, 20));
         exp_q.push_back(3'b011);
         @(posedge clk_in);
         chg <= 1'b1;
         repeat (5) @(negedge clk_in);
         chk({3'h0, en, rstn}, 5'h03);
         @(posedge clk_in);
         press(0, $urandom_range(1, 100));
         press(1, (i == 0) ? 1 : $urandom_range(2, 100));
         repeat (3) @(negedge clk_in);
         chk({4'h0, rstn}, 5'h01);
         @(posedge clk_in);
         exp_q.push_back(3'b111);
         exp_q.push_back(3'b001);
         exp_q.push_back(3'b000);
         press(2, 1);
         repeat (250) @(posedge clk_in);
      end
      // power on again, then reset in mid-run while on
      chg <= 1'b0;
      exp_q.push_back(3'b011);
      @(posedge clk_in);
      chg <= 1'b1;
      repeat (5) @(posedge clk_in);
      sys_rst_in <= 1'b1;
      chg <= 1'b0;
      repeat (3) @(posedge clk_in);
      sys_rst_in <= 1'b0;
      repeat (2) @(negedge clk_in);
      chk({det, en, ps, rstn, pu_en}, 5'h01);
      @(posedge clk_in);
      // software request and short reboot pulse while off change nothing
      press(2, 1);
      press(1, $urandom_range(1, 100));
      repeat (3) @(negedge clk_in);
      chk({det, en, ps, rstn, pu_en}, 5'h01);
      chk({4'h0, exp_q.size() == 0}, 5'h01);
      end_of_test();
   end
endmodule : module_power_toggle_and_reboot_tb
